// file: design/sis_top.sv
// Step indexer, start-up sequencer and Wishbone register slave.
// Assumes all pin inputs are asynchronous; bus runs on core_clk.
`timescale 1ns/1ps

module sis_top
    import sis_pkg::*;
#(
    parameter int OFF_CYCLES = OFF_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        step_clock_a,
    input  wire logic        step_clock_b,
    input  wire logic        dir_sel,
    input  wire logic        step_mode_sel1,
    input  wire logic        step_mode_sel2,
    input  wire logic        step_mode_sel3,
    input  wire logic        enable,
    input  wire logic        drv_reset_n,
    input  wire logic        standby_n,
    input  wire logic        undervoltage_lockout,
    input  wire logic        home_test_sel,
    input  wire logic        cmp_a,
    input  wire logic        cmp_b,
    input  wire logic        gnd_fault_sense,
    output logic      [3:0]  phase_a_output,
    output logic      [3:0]  phase_b_output,
    output logic      [5:0]  step_index,
    output logic             detect_a,
    output logic             detect_b,
    output logic             pump_run,
    output logic             gnd_fault,
    output logic             home_marker_out,
    output logic             home_marker_oe,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o
);
    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    localparam int NPIN = 14;

    logic [NPIN-1:0] pins_raw;
    logic [NPIN-1:0] pins_s;

    assign pins_raw = {gnd_fault_sense, cmp_b, cmp_a, home_test_sel,
                       undervoltage_lockout, standby_n, drv_reset_n,
                       enable, step_mode_sel3, step_mode_sel2,
                       step_mode_sel1, dir_sel, step_clock_b,
                       step_clock_a};

    sis_sync #(
        .WIDTH    (NPIN)
    ) u_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pin_in   (pins_raw),
        .pin_sync (pins_s)
    );

    logic s_clk_a;
    logic s_clk_b;
    logic s_dir;
    logic s_sel1;
    logic s_sel2;
    logic s_sel3;
    logic s_en;
    logic s_rst_n;
    logic s_standby_n_n;
    logic s_undervoltage_lockout;
    logic s_home;
    logic s_cmp_a;
    logic s_cmp_b;
    logic s_gf;

    assign s_clk_a  = pins_s[0];
    assign s_clk_b  = pins_s[1];
    assign s_dir    = pins_s[2];
    assign s_sel1   = pins_s[3];
    assign s_sel2   = pins_s[4];
    assign s_sel3   = pins_s[5];
    assign s_en     = pins_s[6];
    assign s_rst_n  = pins_s[7];
    assign s_standby_n_n = pins_s[8];
    assign s_undervoltage_lockout   = pins_s[9];
    assign s_home   = pins_s[10];
    assign s_cmp_a  = pins_s[11];
    assign s_cmp_b  = pins_s[12];
    assign s_gf     = pins_s[13];

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        sis_state_e  state;
        logic [15:0] cnt;
        logic [5:0]  idx;
        logic        clk_a_d;
        logic        clk_b_d;
        logic        fault;
        logic        hold;
        logic [3:0]  br_a;
        logic [3:0]  br_b;
        logic        pump;
        logic        home_oe;
        logic        home_out;
        logic [31:0] rdata;
        logic        ack;
    } sis_top_s;

    sis_top_s  st_r;
    sis_top_s  st_nxt;
    sis_mode_e mode;
    logic      step_evt;
    logic      powered;
    logic      turn_on_a;
    logic      turn_on_b;
    logic      bus_req;

    assign mode    = sis_mode(s_sel1, s_sel2, s_sel3);
    // Clock A steps on rising edges, clock B on either edge
    assign step_evt = (s_clk_a && !st_r.clk_a_d)
                      || (s_clk_b != st_r.clk_b_d);
    assign powered  = s_standby_n_n && !s_undervoltage_lockout;
    assign bus_req  = wb_cyc_i && wb_stb_i && !st_r.ack;

    // Phase A follows cosine, phase B sine, of the index angle
    function automatic logic [3:0] sis_drive_a(input logic [5:0] i);
        logic [3:0] b;
        b = BR_OFF;
        if (i == 6'h10 || i == 6'h30)
            b = BR_OFF;
        else if (i < 6'h10 || i > 6'h30)
            b = BR_POS;
        else
            b = BR_NEG;
        return b;
    endfunction

    function automatic logic [3:0] sis_drive_b(input logic [5:0] i);
        logic [3:0] b;
        b = BR_OFF;
        if (i == 6'h00 || i == 6'h20)
            b = BR_OFF;
        else if (i < 6'h20)
            b = BR_POS;
        else
            b = BR_NEG;
        return b;
    endfunction

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.clk_a_d = s_clk_a;
        st_nxt.clk_b_d = s_clk_b;

        // Indexer; direction changes act on the held index only
        if (!powered || !s_rst_n)
            st_nxt.idx = IDX_DEFAULT;
        else if (step_evt && !s_dir)
            st_nxt.idx = st_r.idx + sis_step(mode);
        else if (step_evt)
            st_nxt.idx = st_r.idx - sis_step(mode);

        // Start-up sequencer
        st_nxt.pump = powered;
        if (!powered)
        begin
            st_nxt.state = SIS_ST_SLEEP;
            st_nxt.cnt   = '0;
            st_nxt.fault = 1'b0;
        end
        else
        begin
            unique case (st_r.state)
                SIS_ST_SLEEP:
                begin
                    st_nxt.state = SIS_ST_OFFWAIT;
                    st_nxt.cnt   = '0;
                end
                SIS_ST_OFFWAIT:
                begin
                    if (st_r.cnt == 16'(OFF_CYCLES - 1))
                    begin
                        st_nxt.cnt = '0;
                        if (s_rst_n)
                            st_nxt.state = SIS_ST_GFCHECK;
                        else
                            st_nxt.state = SIS_ST_RUN;
                    end
                    else
                        st_nxt.cnt = st_r.cnt + 16'h0001;
                end
                SIS_ST_GFCHECK:
                begin
                    // Sense only after the switch-on blanking settles
                    if (st_r.cnt >= 16'(BLANK_CYC) && s_gf)
                    begin
                        st_nxt.fault = 1'b1;
                        st_nxt.state = SIS_ST_FAULT;
                    end
                    else if (st_r.cnt == 16'(GF_CYC - 1))
                    begin
                        st_nxt.state = SIS_ST_RUN;
                        st_nxt.cnt   = '0;
                    end
                    else
                        st_nxt.cnt = st_r.cnt + 16'h0001;
                end
                SIS_ST_RUN:
                    st_nxt.cnt = '0;
                SIS_ST_FAULT:
                begin
                    // Latched until reset pin low or power release
                    if (!s_rst_n)
                    begin
                        st_nxt.fault = 1'b0;
                        st_nxt.state = SIS_ST_RUN;
                    end
                end
                default:
                    st_nxt.state = SIS_ST_SLEEP;
            endcase
        end

        // Bridge drive
        st_nxt.br_a = BR_OFF;
        st_nxt.br_b = BR_OFF;
        if (st_nxt.state == SIS_ST_GFCHECK)
        begin
            st_nxt.br_a = BR_GF;
            st_nxt.br_b = BR_GF;
        end
        else if (st_nxt.state == SIS_ST_RUN && s_rst_n && s_en
                 && !st_r.hold)
        begin
            st_nxt.br_a = sis_drive_a(st_nxt.idx);
            st_nxt.br_b = sis_drive_b(st_nxt.idx);
        end

        // Home marker pulls low at the 45 degree points shared by all modes
        st_nxt.home_out = 1'b0;
        st_nxt.home_oe  = s_home && powered && s_rst_n
                          && (st_nxt.idx[3:0] == IDX_HOME);

        // Wishbone slave: one ack per request, dropped the next cycle
        st_nxt.ack = bus_req;
        if (bus_req && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0])
            st_nxt.hold = wb_dat_i[CTRL_HOLD];
        st_nxt.rdata = '0;
        if (bus_req && !wb_we_i)
        begin
            if (wb_adr_i == REG_CTRL)
                st_nxt.rdata[CTRL_HOLD] = st_r.hold;
            else if (wb_adr_i == REG_STATUS)
            begin
                st_nxt.rdata[ST_STATE +: 3] = st_r.state;
                st_nxt.rdata[ST_FAULT]      = st_r.fault;
                st_nxt.rdata[ST_PUMP]       = st_r.pump;
                st_nxt.rdata[ST_HOME]       = st_r.home_oe;
                st_nxt.rdata[ST_INDEX +: 6] = st_r.idx;
                st_nxt.rdata[ST_MODE +: 3]  = mode;
            end
        end
    end

    assign turn_on_a = (st_nxt.br_a != BR_OFF) && (st_nxt.br_a != st_r.br_a);
    assign turn_on_b = (st_nxt.br_b != BR_OFF) && (st_nxt.br_b != st_r.br_b);

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r       <= '0;
            st_r.state <= SIS_ST_SLEEP;
            st_r.idx   <= IDX_DEFAULT;
            st_r.hold  <= CTRL_RESET;
        end
        else
            st_r <= st_nxt;
    end

    // ************************************************************
    // Current-detect blanking per phase
    // ************************************************************
    sis_blank u_blank_a (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .turn_on  (turn_on_a),
        .driving  (st_r.br_a != BR_OFF),
        .cmp_sync (s_cmp_a),
        .detect   (detect_a)
    );

    sis_blank u_blank_b (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .turn_on  (turn_on_b),
        .driving  (st_r.br_b != BR_OFF),
        .cmp_sync (s_cmp_b),
        .detect   (detect_b)
    );

    assign phase_a_output  = st_r.br_a;
    assign phase_b_output  = st_r.br_b;
    assign step_index      = st_r.idx;
    assign pump_run        = st_r.pump;
    assign gnd_fault       = st_r.fault;
    assign home_marker_out = st_r.home_out;
    assign home_marker_oe  = st_r.home_oe;
    assign wb_dat_o        = st_r.rdata;
    assign wb_ack_o        = st_r.ack;

endmodule

// file: design/sis_pkg.sv
// Constants, types and decoders of the step indexer and start sequencer.
// Assumes a single 100 MHz core clock and a classic Wishbone register bus.

package sis_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ        = 100;
    localparam int OFF_TIME_US    = 400;
    localparam int GF_TIME_NS     = 6000;
    localparam int BLANK_TIME_NS  = 750;
    localparam int OFF_CYC        = OFF_TIME_US * CLK_MHZ;
    localparam int GF_CYC         = GF_TIME_NS * CLK_MHZ / 1000;
    localparam int BLANK_CYC      = BLANK_TIME_NS * CLK_MHZ / 1000;

    // ************************************************************
    // Step index: 64 positions per electrical turn, 0 is 0 degrees
    // ************************************************************
    localparam logic [5:0] IDX_DEFAULT = 6'h38;
    localparam logic [3:0] IDX_HOME    = 4'h8;

    // Bridge switch code {upper1, lower1, upper2, lower2}
    localparam logic [3:0] BR_OFF = 4'h0;
    localparam logic [3:0] BR_POS = 4'h9;
    localparam logic [3:0] BR_NEG = 4'h6;
    localparam logic [3:0] BR_GF  = 4'hA;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0] REG_CTRL    = 4'h0;
    localparam logic [3:0] REG_STATUS  = 4'h4;
    localparam int         CTRL_HOLD   = 0;
    localparam int         ST_STATE    = 0;
    localparam int         ST_FAULT    = 4;
    localparam int         ST_PUMP     = 5;
    localparam int         ST_HOME     = 6;
    localparam int         ST_INDEX    = 8;
    localparam int         ST_MODE     = 16;
    localparam logic       CTRL_RESET  = 1'b0;

    typedef enum logic [2:0] {
        SIS_MODE_2PH,
        SIS_MODE_12,
        SIS_MODE_16,
        SIS_MODE_32,
        SIS_MODE_64
    } sis_mode_e;

    typedef enum logic [2:0] {
        SIS_ST_SLEEP,
        SIS_ST_OFFWAIT,
        SIS_ST_GFCHECK,
        SIS_ST_RUN,
        SIS_ST_FAULT
    } sis_state_e;

    // Mode select pins to excitation mode
    function automatic sis_mode_e sis_mode(input logic s1, input logic s2,
                                           input logic s3);
        sis_mode_e m;
        m = SIS_MODE_2PH;
        if (s3)
            m = s1 ? SIS_MODE_64 : SIS_MODE_32;
        else if (s1 && s2)
            m = SIS_MODE_16;
        else if (s1)
            m = SIS_MODE_12;
        return m;
    endfunction

    // Index increment of one step in a mode
    function automatic logic [5:0] sis_step(input sis_mode_e m);
        logic [5:0] d;
        d = 6'h10;
        unique case (m)
            SIS_MODE_2PH: d = 6'h10;
            SIS_MODE_12:  d = 6'h08;
            SIS_MODE_16:  d = 6'h04;
            SIS_MODE_32:  d = 6'h02;
            SIS_MODE_64:  d = 6'h01;
        endcase
        return d;
    endfunction

endpackage

// file: design/sis_sync.sv
// Two-stage synchroniser for the asynchronous pin inputs.
// Assumes inputs change slowly compared with the core clock.
`timescale 1ns/1ps

module sis_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sis_sync_s;

    sis_sync_s st_r;
    sis_sync_s st_nxt;

    always_comb
    begin
        st_nxt.meta = pin_in;
        st_nxt.sync = st_r.meta;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign pin_sync = st_r.sync;

endmodule

// file: design/sis_blank.sv
// Current-detect blanking for one bridge phase.
// Assumes the comparator input is already synchronised to core_clk.
`timescale 1ns/1ps

module sis_blank
    import sis_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic turn_on,
    input  wire logic driving,
    input  wire logic cmp_sync,
    output logic      detect
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       detect;
    } sis_blank_s;

    sis_blank_s st_r;
    sis_blank_s st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (turn_on)
            st_nxt.cnt = 8'(BLANK_CYC);
        else if (st_r.cnt != 8'h00)
            st_nxt.cnt = st_r.cnt - 8'h01;
        // Comparator noise at switch-on is not a current peak
        st_nxt.detect = driving && !turn_on && (st_r.cnt == 8'h00)
                        && cmp_sync;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign detect = st_r.detect;

endmodule

// file: testbench/sis_monitor.sv
// Port-level checks of the step indexer and start-up sequencer.
// Assumes a bind into sis_top; pins pass two sync stages.
`timescale 1ns/1ps

module sis_monitor
    import sis_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       sys_rst,
    input wire logic       step_clock_a,
    input wire logic       step_clock_b,
    input wire logic       dir_sel,
    input wire logic       step_mode_sel1,
    input wire logic       step_mode_sel2,
    input wire logic       step_mode_sel3,
    input wire logic       enable,
    input wire logic       drv_reset_n,
    input wire logic       standby_n,
    input wire logic       undervoltage_lockout,
    input wire logic       home_test_sel,
    input wire logic [3:0] phase_a_output,
    input wire logic [3:0] phase_b_output,
    input wire logic [5:0] step_index,
    input wire logic       detect_a,
    input wire logic       pump_run,
    input wire logic       gnd_fault,
    input wire logic       home_marker_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    logic off;
    assign off = phase_a_output == BR_OFF && phase_b_output == BR_OFF;

    // Own step table, kept apart from the design decoder
    function automatic logic [5:0] nxt(logic [5:0] i, logic d);
        logic [5:0] s;
        s = 6'h01 << (step_mode_sel3 ? (step_mode_sel1 ? 0 : 1)
            : step_mode_sel1 ? (step_mode_sel2 ? 2 : 3) : 4);
        return d ? i - s : i + s;
    endfunction

    // ************************************************************
    // Properties
    // ************************************************************
    sequence s_edge;
        ($rose(step_clock_a) || $changed(step_clock_b)) && drv_reset_n
            && standby_n && !undervoltage_lockout;
    endsequence
    sequence s_gf;
        phase_b_output == BR_GF && drv_reset_n;
    endsequence
    property p_step;
        s_edge |-> ##3 step_index == nxt($past(step_index), dir_sel);
    endproperty
    property p_dflt;
        (!drv_reset_n || !standby_n || undervoltage_lockout) [*4]
            |-> step_index == IDX_DEFAULT;
    endproperty
    property p_off;
        (!enable || !drv_reset_n || !standby_n || undervoltage_lockout)
            [*4] |-> off;
    endproperty
    property p_gf;
        $rose(phase_a_output == BR_GF) |-> s_gf [*8];
    endproperty
    property p_fault;
        gnd_fault && $past(gnd_fault) |-> off;
    endproperty
    property p_pump;
        $stable({standby_n, undervoltage_lockout}) [*4]
            |-> pump_run == (standby_n && !undervoltage_lockout);
    endproperty
    property p_blank;
        $changed(phase_a_output) |=> !detect_a [*8];
    endproperty
    property p_home;
        !home_test_sel [*4] |-> !home_marker_oe;
    endproperty

    a_step: assert property (p_step)
        else $error("step index moved wrongly");
    a_dflt: assert property (p_dflt)
        else $error("index not at default");
    a_off: assert property (p_off)
        else $error("bridges driven while stopped");
    a_gf: assert property (p_gf)
        else $error("ground check pattern wrong");
    a_fault: assert property (p_fault)
        else $error("bridges driven after ground fault");
    a_pump: assert property (p_pump)
        else $error("pump state wrong");
    a_blank: assert property (p_blank)
        else $error("detect inside blanking");
    a_home: assert property (p_home)
        else $error("marker active without test select");
endmodule

// file: testbench/sis_ctrl_model.sv
// Step controller model: step clocks, direction and mode pins.
// Assumes one caller at a time, entered just after a rising edge.
`timescale 1ns/1ps

module sis_ctrl_model #(
    parameter int PULSE_CYC = 1000,
    parameter int SETUP_CYC = 200
) (
    input  wire logic core_clk,
    output logic      step_clock_a,
    output logic      step_clock_b,
    output logic      dir_sel,
    output logic      step_mode_sel1,
    output logic      step_mode_sel2,
    output logic      step_mode_sel3
);
    initial
    begin
        {step_clock_a, step_clock_b, dir_sel} = 3'h0;
        {step_mode_sel1, step_mode_sel2, step_mode_sel3} = 3'h0;
    end

    // Extra wait w makes the controller slow at random
    task automatic step(input logic b, input logic d,
                        input logic [2:0] m, input int w);
        dir_sel <= d;
        {step_mode_sel1, step_mode_sel2, step_mode_sel3} <= m;
        repeat (SETUP_CYC) @(posedge core_clk);
        if (b)
            step_clock_b <= !step_clock_b;
        else
            step_clock_a <= 1'b1;
        repeat (PULSE_CYC + w) @(posedge core_clk);
        step_clock_a <= 1'b0;
        repeat (PULSE_CYC) @(posedge core_clk);
    endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench of the step indexer and start-up sequencer.
// Assumes sis_top, the controller model and the monitor are compiled.
`timescale 1ns/1ps

module tb;
    import sis_pkg::*;
    localparam int OFF = 50;
    logic        core_clk, sys_rst, enable, drv_reset_n, standby_n;
    logic        undervoltage_lockout, home_test_sel, cmp_a, home_marker_out;
    logic        gnd_fault_sense, step_clock_a, step_clock_b, dir_sel;
    logic        step_mode_sel1, step_mode_sel2, step_mode_sel3;
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [3:0]  wb_adr_i, wb_sel_i, phase_a_output, phase_b_output;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [5:0]  step_index, idx;
    logic        detect_a, detect_b, pump_run, gnd_fault, home_marker_oe;
    int          miscompares, tests_run, seed, n, g;
    logic [2:0]  modes [5] = '{3'h0, 3'h4, 3'h6, 3'h1, 3'h5};

    sis_top #(.OFF_CYCLES(OFF)) u_sis_top (
        .core_clk, .sys_rst, .step_clock_a, .step_clock_b, .dir_sel,
        .step_mode_sel1, .step_mode_sel2, .step_mode_sel3, .enable,
        .drv_reset_n, .standby_n, .undervoltage_lockout, .home_test_sel,
        .cmp_a, .cmp_b(cmp_a), .gnd_fault_sense, .phase_a_output,
        .phase_b_output, .step_index, .detect_a, .detect_b, .pump_run,
        .gnd_fault, .home_marker_out, .home_marker_oe, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o
    );
    sis_ctrl_model u_sis_ctrl_model (
        .core_clk, .step_clock_a, .step_clock_b, .dir_sel,
        .step_mode_sel1, .step_mode_sel2, .step_mode_sel3
    );

    always #5 core_clk = ~core_clk;

    // ************************************************************
    // Tasks
    // ************************************************************
    function automatic logic [5:0] exp_step(logic [5:0] i, logic d,
                                            logic [2:0] m);
        logic [5:0] s;
        s = 6'h01 << (m[0] ? (m[2] ? 0 : 1) : m[2] ? (m[1] ? 2 : 3) : 4);
        return d ? i - s : i + s;
    endfunction

    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] v);
        tests_run++;
        if (v !== e)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", s, e, v);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wb(input logic we, input logic [3:0] a,
                      input logic [31:0] d);
        int k;
        k = 0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'h3, we, a, 4'hF};
        wb_dat_i <= d;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (wb_ack_o !== 1'b1 && k < 50);
        chk("ack", 32'h1, wb_ack_o);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        @(posedge core_clk);
    endtask

    task automatic step(input logic b, input logic d, input logic [2:0] m);
        u_sis_ctrl_model.step(b, d, m, $random(seed) & 255);
        idx = exp_step(idx, d, m);
        repeat (5) @(posedge core_clk);
    endtask

    task automatic power_up();
        n = 0;
        g = 0;
        standby_n <= 1'b1;
        while (phase_a_output !== BR_GF && n < OFF + 20)
        begin
            @(posedge core_clk);
            n++;
        end
        while (phase_a_output === BR_GF && g < 700)
        begin
            @(posedge core_clk);
            g++;
        end
    endtask

    // ************************************************************
    // Sequence
    // ************************************************************
    initial
    begin
        {core_clk, sys_rst, enable, drv_reset_n} = 4'h7;
        {standby_n, undervoltage_lockout, home_test_sel} = 3'h0;
        {cmp_a, gnd_fault_sense} = 2'h0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} = 11'h0;
        wb_dat_i = 32'h0;
        seed = 59;
        idx = IDX_DEFAULT;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (5) @(posedge core_clk);
        chk("pump", 32'h0, pump_run);
        chk("index", IDX_DEFAULT, step_index);
        wb(1'b0, REG_STATUS, 32'h0);
        chk("state", SIS_ST_SLEEP, rd[2:0]);
        wb(1'b1, REG_CTRL, 32'h1);
        wb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl", 32'h1, rd);
        wb(1'b0, 4'hC, 32'h0);
        chk("unmapped", 32'h0, rd);
        wb(1'b1, REG_CTRL, 32'h0);
        cmp_a <= 1'b1;
        power_up();
        chk("off_span", 32'h1, n >= OFF && n <= OFF + 4);
        chk("gf_span", GF_CYC, g);
        chk("run_a", BR_POS, phase_a_output);
        chk("run_b", BR_NEG, phase_b_output);
        n = 0;
        while (detect_a !== 1'b1 && n < 200)
        begin
            @(posedge core_clk);
            n++;
        end
        chk("blank", 32'h1, n >= BLANK_CYC - 5 && n <= BLANK_CYC + 5);
        chk("blank_b", 32'h1, detect_b);
        wb(1'b0, REG_STATUS, 32'h0);
        chk("status", {SIS_ST_RUN, 1'b1}, {rd[2:0], rd[ST_PUMP]});
        for (int i = 0; i < 14; i++)
        begin
            enable <= i < 5 ? 1'b1 : 1'($random(seed));
            step(1'(i), 1'(i >> 1),
                 i < 5 ? modes[i] : modes[$unsigned($random(seed)) % 5]);
            chk("index", idx, step_index);
            if (!enable)
                chk("en_off", BR_OFF, phase_a_output);
        end
        enable <= 1'b1;
        drv_reset_n <= 1'b0;
        step(1'b0, 1'b0, modes[4]);
        idx = IDX_DEFAULT;
        chk("rst_index", idx, step_index);
        chk("rst_off", BR_OFF, phase_a_output);
        drv_reset_n <= 1'b1;
        home_test_sel <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk("restart", idx, step_index);
        chk("home_on", 32'h1, home_marker_oe);
        chk("home_out", 32'h0, home_marker_out);
        step(1'b0, 1'b0, modes[4]);
        chk("home_off", 32'h0, home_marker_oe);
        home_test_sel <= 1'b0;
        undervoltage_lockout <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk("uv_pump", 32'h0, pump_run);
        chk("uv_index", IDX_DEFAULT, step_index);
        drv_reset_n <= 1'b0;
        undervoltage_lockout <= 1'b0;
        enable <= 1'b0;
        power_up();
        chk("no_gf", 32'h0, g);
        drv_reset_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk("en_low", BR_OFF, phase_a_output);
        enable <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk("en_high", BR_POS, phase_a_output);
        standby_n <= 1'b0;
        gnd_fault_sense <= 1'b1;
        repeat (5) @(posedge core_clk);
        power_up();
        repeat (4) @(posedge core_clk);
        chk("gf_flag", 32'h1, gnd_fault);
        chk("gf_off", BR_OFF, phase_b_output);
        print_verdict();
    end

    initial
    begin
        repeat (90000) @(posedge core_clk);
        miscompares++;
        print_verdict();
    end
endmodule

bind sis_top sis_monitor u_sis_monitor (
    .core_clk, .sys_rst, .step_clock_a, .step_clock_b, .dir_sel,
    .step_mode_sel1, .step_mode_sel2, .step_mode_sel3, .enable,
    .drv_reset_n, .standby_n, .undervoltage_lockout, .home_test_sel,
    .phase_a_output, .phase_b_output, .step_index, .detect_a,
    .pump_run, .gnd_fault, .home_marker_oe
);
